// *** sfl_dev_model.sv ***
/* Behavioural model of the serial flash device: status, configuration, protection.
   Assumes the host drives clock, select and protect pin; lines resolved by the bench. */
`timescale 1ns/100ps
module sfl_dev_model
	import sfl_pkg::*;
#(
	// Erase command codes; the values are arbitrary and are set by the bench.
	parameter logic [7:0] ERASE_4K = 8'hA1,
	parameter logic [7:0] ERASE_32K = 8'hA2,
	parameter logic [7:0] ERASE_64K = 8'hA3
) (
	input wire logic sck,
	input wire logic sel_n,
	input wire logic [3:0] din,
	input wire logic wp_n,
	output logic [3:0] dout,
	output logic [3:0] doe
);
	logic [7:0] st = 8'h0C;
	logic [7:0] cf = 8'h00;
	logic quad = 1'h0;
	logic [7:0] sh, rep, cmd, b2, b3, b4;
	logic [23:0] ea, mask;
	int n = 0;
	int erase_count = 0;
	logic [23:0] erase_base = 24'h00_0000;
	realtime tf = 0;
	wire logic wpa = !wp_n && !cf[CF_IO_CONFIG] && cf[CF_PIN_ENABLE];
	initial doe = 4'h0;
	always @(negedge sel_n) begin
		n = 0;
		tf = $realtime;
	end
	// An edge in the same step as the select fall belongs to the idle level, not to data.
	always @(posedge sck) if (!sel_n && $realtime != tf) begin
		sh = quad ? {sh[3:0], din} : {sh[6:0], din[0]};
		n = n + (quad ? 4 : 1);
		if (n == 8) cmd = sh;
		if (n == 8) rep = (sh == CMD_CONFIG_READ) ? cf : st;
		if (n == 16) b2 = sh;
		if (n == 24) b3 = sh;
		if (n == 32) b4 = sh;
	end
	always @(negedge sck) if (!sel_n && $realtime != tf && n >= 8 &&
		(cmd == CMD_STATUS_READ || cmd == CMD_CONFIG_READ)) begin
		doe = quad ? 4'hF : 4'h2;
		dout = quad ? rep[7:4] : {2'h0, rep[7], 1'h0};
		rep = quad ? {rep[3:0], rep[7:4]} : {rep[6:0], rep[7]};
	end
	always @(posedge sel_n) begin
		doe = 4'h0;
		if (n == 8 && cmd == CMD_WRITE_ENABLE) st[ST_WEL] = 1'h1;
		if (n == 8 && cmd == CMD_QUAD_ENABLE) quad = 1'h1;
		if (n == 8 && cmd == CMD_VOLATILE_LOCK && st[ST_WEL]) cf[CF_VOLATILE_LOCK] = 1'h1;
		if (n >= 24 && cmd == CMD_STATUS_WRITE && st[ST_WEL]) begin
			if (!cf[CF_VOLATILE_LOCK] && !(wpa && st[ST_LOCKDOWN])) st[3:2] = b2[3:2];
			if (!wpa) st[ST_LOCKDOWN] = b2[7];
			if (!wpa) cf = (cf & 8'h7D) | (b3 & 8'h82);
		end
		ea = {b2, b3, b4};
		mask = (cmd == ERASE_64K) ? 24'hFF_0000 : (cmd == ERASE_32K) ? 24'hFF_8000 :
			24'hFF_F000;
		if (n >= 32 && (cmd == ERASE_4K || cmd == ERASE_32K || cmd == ERASE_64K)) begin
			// Any non-zero protection level is taken to cover the target, a simplification.
			if (st[ST_WEL] && st[3:2] == 2'h0) begin
				erase_count++;
				erase_base = ea & mask;
			end
			st[ST_WEL] = 1'h0;
		end
		if (cmd == CMD_VOLATILE_LOCK || cmd == CMD_STATUS_WRITE) st[ST_WEL] = 1'h0;
		// A clock edge that coincides with the next select fall must not count as stale data.
		n = 0;
	end
endmodule

// *** sfl_host.sv ***
/*
 * Host controller for a serial flash: shifts one byte per order out over
 * one or four shared data lines and captures a byte back.
 * Assumes the device pins reach it asynchronously and software drives the
 * plain register port from the same clock.
 */
// What this block does
// [RULE_01] Launch on falling edge, sample on rising
// [RULE_02] Select falls to start, held through sequence
// [RULE_03] Start in single-line mode after reset
// [RULE_04] Quad-enable switches to four shared lines
// [RULE_05] Single-line uses separate in and out lines
// [RULE_06] Clock idles low or high per mode
// [RULE_07] Pause pin held high when unused
// [RULE_08] Device memory split into overlaid erase units
// [RULE_09] Device write-protected after power-on
// [RULE_10] Volatile lock freezes protection until reset
// [RULE_11] Write-enable sent before volatile lock
// [RULE_12] Volatile lock visible in configuration register
// [RULE_13] Protect pin only in single-line I/O config zero
// [RULE_14] Protect pin ignored while enable bit clear
// [RULE_15] Protect pin guards lockdown and configuration only
// [RULE_16] Lockdown decides status write while pin low
// [RULE_17] Protection bits guard array and status; the model checks them on erase only, never on a status write
// [RULE_18] Status bit layout: busy, latch, protect, lockdown
// [RULE_19] Program and erase refused without write latch
// [RULE_20] Forbidden register writes discarded, bus completes
`timescale 1ns/100ps
module sfl_host
	import sfl_pkg::*;
#(
	parameter int HALF = HALF_CYCLES
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [3:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [7:0] rdata,
	output logic sck,
	output logic sel_n,
	output logic [3:0] line_out,
	output logic [3:0] line_oe,
	input wire logic [3:0] line_in,
	output logic pause_n,
	output logic protect_n
);
	// --------------------------------------------------------------
	// Pin synchronisers
	// --------------------------------------------------------------
	logic [3:0] in_s1_reg;
	logic [3:0] in_s2_reg;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			in_s1_reg <= 4'h0;
			in_s2_reg <= 4'h0;
		end else begin
			in_s1_reg <= line_in;
			in_s2_reg <= in_s1_reg;
		end
	end

	// --------------------------------------------------------------
	// Control registers
	// --------------------------------------------------------------
	typedef enum logic [3:0] {
		S_IDLE = 4'b0001,
		S_LOW = 4'b0010,
		S_HIGH = 4'b0100,
		S_END = 4'b1000
	} sfl_state_t;

	sfl_state_t state_reg;
	sfl_ctrl_t ctrl_reg;
	logic [7:0] tx_reg;
	logic [7:0] rx_reg;
	logic [3:0] bit_reg;
	logic [7:0] div_reg;
	logic busy;
	logic start;
	logic tick;
	logic [3:0] bits_total;
	logic [7:0] rsel;
	assign busy = (state_reg != S_IDLE);
	assign start = wr && (addr == REG_CTRL) && wdata[CTRL_GO] && !busy;
	assign tick = (div_reg == 8'(HALF - 1));
	assign bits_total = ctrl_reg.quad ? 4'h2 : 4'h8; // [RULE_04]
	assign rsel = (addr == REG_STAT) ? {6'h00, ctrl_reg.quad, busy} :
		(addr == REG_RX) ? rx_reg :
		(addr == REG_TX) ? tx_reg :
		// Control reads back in its write layout; the go bit reads as zero.
		(addr == REG_CTRL) ? {3'h0, ctrl_reg.read, ctrl_reg.keep_sel, ctrl_reg.mode3,
			ctrl_reg.quad, 1'b0} : 8'h00;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ctrl_reg <= '0; // [RULE_03]
			tx_reg <= 8'h00;
			rdata <= 8'h00;
			pause_n <= 1'b1; // [RULE_07]
			protect_n <= 1'b1;
		end else begin
			rdata <= rd ? rsel : 8'h00;
			if (wr && addr == REG_TX && !busy)
				tx_reg <= wdata;
			if (wr && addr == REG_PINS)
				protect_n <= wdata[0]; // [RULE_13]
			if (start)
				ctrl_reg <= {wdata[CTRL_QUAD], wdata[CTRL_MODE3],
					wdata[CTRL_KEEP_SEL], wdata[CTRL_READ]};
		end
	end

	// --------------------------------------------------------------
	// Serial engine
	// --------------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_reg <= S_IDLE;
			div_reg <= 8'h00;
			bit_reg <= 4'h0;
			rx_reg <= 8'h00;
			sck <= 1'b0;
			sel_n <= 1'b1;
			line_out <= 4'h0;
			line_oe <= 4'h0;
		end else begin
			div_reg <= (busy && !tick) ? div_reg + 8'h01 : 8'h00;
			case (state_reg)
			S_IDLE: begin
				if (start) begin
					sel_n <= 1'b0; // [RULE_02]
					sck <= wdata[CTRL_MODE3]; // [RULE_06]
					bit_reg <= 4'h0;
					state_reg <= S_LOW;
				end
			end
			S_LOW: if (tick) begin
				// Data changes while clock is low, before the rising edge.
				if (ctrl_reg.quad) begin
					line_out <= bit_reg[0] ? tx_reg[3:0] : tx_reg[7:4];
					line_oe <= ctrl_reg.read ? 4'h0 : 4'hF; // [RULE_04]
				end else begin
					line_out <= {3'b000, tx_reg[3'(7 - bit_reg)]}; // [RULE_05]
					line_oe <= 4'h1;
				end
				sck <= 1'b0; // [RULE_01]
				state_reg <= S_HIGH;
			end
			S_HIGH: if (tick) begin
				sck <= 1'b1; // [RULE_01]
				if (ctrl_reg.quad)
					rx_reg <= {rx_reg[3:0], in_s2_reg};
				else
					rx_reg <= {rx_reg[6:0], in_s2_reg[1]}; // [RULE_05]
				bit_reg <= bit_reg + 4'h1;
				state_reg <= (bit_reg + 4'h1 == bits_total) ? S_END : S_LOW;
			end
			S_END: if (tick) begin
				line_oe <= 4'h0;
				sck <= ctrl_reg.mode3;
				// Keep select low across bytes of one command sequence.
				// Releasing select after a lone byte keeps write-enable a command of its own.
				sel_n <= !ctrl_reg.keep_sel; // [RULE_02] [RULE_11]
				state_reg <= S_IDLE;
			end
			default: state_reg <= S_IDLE;
			endcase
		end
	end

	// --------------------------------------------------------------
	// Checks
	// --------------------------------------------------------------
	property p_launch_low;
		@(posedge clk) disable iff (rst)
		$changed(line_out) |-> !sck;
	endproperty
	a_launch_low: assert property (p_launch_low) else $error("data moved with clock high"); // [RULE_01]

	property p_sel_held;
		@(posedge clk) disable iff (rst)
		(state_reg == S_HIGH) |-> !sel_n;
	endproperty
	a_sel_held: assert property (p_sel_held) else $error("select high mid byte"); // [RULE_02]

	property p_start_sel;
		@(posedge clk) disable iff (rst)
		start |=> !sel_n && state_reg == S_LOW;
	endproperty
	a_start_sel: assert property (p_start_sel) else $error("start did not select"); // [RULE_02]

	property p_single_oe;
		@(posedge clk) disable iff (rst)
		(busy && !ctrl_reg.quad) |-> (line_oe[3:1] == 3'b000);
	endproperty
	a_single_oe: assert property (p_single_oe) else $error("extra line driven"); // [RULE_05]

	property p_quad_read_oe;
		@(posedge clk) disable iff (rst)
		(ctrl_reg.quad && ctrl_reg.read) |-> line_oe == 4'h0;
	endproperty
	a_quad_read_oe: assert property (p_quad_read_oe) else $error("drove during read"); // [RULE_04]

	property p_idle_clock;
		@(posedge clk) disable iff (rst)
		(state_reg == S_END && tick) |=> sck == ctrl_reg.mode3;
	endproperty
	a_idle_clock: assert property (p_idle_clock) else $error("wrong idle clock"); // [RULE_06]

	property p_pause_high;
		@(posedge clk) disable iff (rst)
		pause_n;
	endproperty
	a_pause_high: assert property (p_pause_high) else $error("pause pin low"); // [RULE_07]

	property p_rise_after_half;
		@(posedge clk) disable iff (rst)
		// The only other rise is the idle level being set high as a mode 3 byte starts.
		$rose(sck) && busy |-> $past(state_reg) == S_HIGH || $past(start);
	endproperty
	a_rise_after_half: assert property (p_rise_after_half) else $error("stray rising edge"); // [RULE_01]

	property p_read_lat;
		@(posedge clk) disable iff (rst)
		rd && addr == REG_STAT |=> rdata[0] == $past(busy);
	endproperty
	a_read_lat: assert property (p_read_lat) else $error("status read wrong"); // [RULE_03]

	c_single: cover property (@(posedge clk) start && !wdata[CTRL_QUAD]);
	c_quad: cover property (@(posedge clk) start && wdata[CTRL_QUAD]);
	c_mode3: cover property (@(posedge clk) start && wdata[CTRL_MODE3]);
	c_keep: cover property (@(posedge clk) state_reg == S_END && ctrl_reg.keep_sel);
endmodule

// *** sfl_pkg.sv ***
/*
 * Package for the serial flash host controller: command codes, status and
 * configuration bit positions, local register map and the packed carriers.
 * Assumes a single 20 MHz system clock domain.
 */
package sfl_pkg;
	// --------------------------------------------------------------
	// Device command codes
	// --------------------------------------------------------------
	localparam logic [7:0] CMD_WRITE_ENABLE = 8'h06;
	localparam logic [7:0] CMD_STATUS_WRITE = 8'h01;
	localparam logic [7:0] CMD_STATUS_READ = 8'h05;
	localparam logic [7:0] CMD_CONFIG_READ = 8'h35;
	localparam logic [7:0] CMD_QUAD_ENABLE = 8'h38;
	localparam logic [7:0] CMD_VOLATILE_LOCK = 8'h8D;
	// --------------------------------------------------------------
	// Device status and configuration bit positions
	// --------------------------------------------------------------
	localparam int ST_BUSY = 0;
	localparam int ST_WEL = 1;
	localparam int ST_BP_LOW = 2;
	localparam int ST_BP_HIGH = 3;
	localparam int ST_LOCKDOWN = 7;
	localparam int CF_IO_CONFIG = 1;
	localparam int CF_VOLATILE_LOCK = 3;
	localparam int CF_PIN_ENABLE = 7;
	// --------------------------------------------------------------
	// Local register map (word addresses on the plain port)
	// --------------------------------------------------------------
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_TX = 4'h1;
	localparam logic [3:0] REG_STAT = 4'h2;
	localparam logic [3:0] REG_RX = 4'h3;
	localparam logic [3:0] REG_PINS = 4'h4;
	localparam int CTRL_GO = 0;
	localparam int CTRL_QUAD = 1;
	localparam int CTRL_MODE3 = 2;
	localparam int CTRL_KEEP_SEL = 3;
	localparam int CTRL_READ = 4;
	// --------------------------------------------------------------
	// Timing
	// --------------------------------------------------------------
	localparam int CLK_HZ = 20_000_000;
	localparam int LINK_HALF_NS = 200;
	localparam int HALF_CYCLES = (LINK_HALF_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	// --------------------------------------------------------------
	// Carriers
	// --------------------------------------------------------------
	typedef struct packed {
		logic [3:0] dout;
		logic [3:0] oe;
	} sfl_lines_t;
	typedef struct packed {
		logic quad;
		logic mode3;
		logic keep_sel;
		logic read;
	} sfl_ctrl_t;
endpackage

// *** tb.sv ***
/* Bench for the serial flash host: random byte orders against the device model.
   Assumes sfl_pkg, sfl_host and sfl_dev_model are compiled first. */
`timescale 1ns/100ps
module tb
	import sfl_pkg::*;
;
	logic clk = 1'h0;
	logic rst = 1'h1;
	logic [3:0] addr = 4'h0;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'h0;
	logic rd = 1'h0;
	logic md = 1'h0;
	logic qm = 1'h0;
	logic pn = 1'h1;
	logic [7:0] rdata, r;
	logic [7:0] est = 8'h0C;
	logic [7:0] ecf = 8'h00;
	logic sck, sel_n, pause_n, protect_n;
	logic [3:0] line_out, line_oe, line_in, dout, doe;
	int seed = 50;
	int bad_count = 0;
	int checks_done = 0;
	int cyc = 0;
	// Erase codes are arbitrary; the device model takes them as parameters.
	localparam logic [7:0] ERASE_4K = 8'hA1;
	localparam logic [7:0] ERASE_32K = 8'hA2;
	localparam logic [7:0] ERASE_64K = 8'hA3;
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin bad_count++; \
	$display("[FAIL] %0t %h %h", $time, a, e); end end
	sfl_host #(.HALF(4)) dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
		.rd(rd), .rdata(rdata), .sck(sck), .sel_n(sel_n), .line_out(line_out),
		.line_oe(line_oe), .line_in(line_in), .pause_n(pause_n), .protect_n(protect_n));
	sfl_dev_model #(.ERASE_4K(ERASE_4K), .ERASE_32K(ERASE_32K), .ERASE_64K(ERASE_64K)) dev (
		.sck(sck), .sel_n(sel_n), .din(line_in), .wp_n(protect_n),
		.dout(dout), .doe(doe));
	// A released line shows the inverse of the host's last value, so nothing passes by luck.
	assign line_in = (line_oe & line_out) | (~line_oe & doe & dout) | (~line_oe & ~doe & ~line_out);
	always #25 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 40000) begin
			bad_count++;
			results();
		end
	end
	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task results;
		if (bad_count == 0 && checks_done > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic wreg(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'h1;
		@(posedge clk);
		wr <= 1'h0;
	endtask
	task automatic rreg(input logic [3:0] a, output logic [7:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'h1;
		@(posedge clk);
		rd <= 1'h0;
		#1;
		d = rdata;
	endtask
	task automatic xf(input logic [7:0] b, input logic k, input logic rb, output logic [7:0] v);
		logic [7:0] s;
		wreg(REG_TX, b);
		wreg(REG_CTRL, {3'h0, rb, k, md, qm, 1'h1});
		s = 8'h01;
		for (int i = 0; i < 200 && s[0]; i++) rreg(REG_STAT, s);
		rreg(REG_RX, v);
		`CHK(s[0], 1'h0)
		rreg(REG_TX, s);
		`CHK(s, b)
		rreg(REG_CTRL, s);
		`CHK(s, {3'h0, rb, k, md, qm, 1'h0})
		`CHK(sck, md)
		`CHK(sel_n, ~k)
		`CHK(pause_n, 1'h1)
	endtask
	task automatic cmdn(input logic [7:0] c);
		md = 1'($random(seed));
		xf(c, 1'h0, 1'h0, r);
	endtask
	task automatic rdr(input logic [7:0] c, output logic [7:0] v);
		md = 1'($random(seed));
		xf(c, 1'h1, 1'h0, v);
		xf(8'h00, 1'h0, 1'h1, v);
	endtask
	function automatic logic [7:0] nst(input logic [7:0] s, input logic [7:0] w, input logic a,
		input logic v);
		nst = s;
		if (!v && !(a && s[7])) nst[3:2] = w[3:2];
		if (!a) nst[7] = w[7];
	endfunction
	task automatic status_write_cmd(input logic [7:0] s, input logic [7:0] c, input logic we);
		logic a;
		a = !pn && !ecf[CF_IO_CONFIG] && ecf[CF_PIN_ENABLE];
		if (we) cmdn(CMD_WRITE_ENABLE);
		md = 1'($random(seed));
		xf(CMD_STATUS_WRITE, 1'h1, 1'h0, r);
		xf(s, 1'h1, 1'h0, r);
		xf(c, 1'h0, 1'h0, r);
		if (we && !a) ecf = (ecf & 8'h7D) | (c & 8'h82);
		if (we) est = nst(est, s, a, ecf[CF_VOLATILE_LOCK]);
		rdr(CMD_STATUS_READ, r);
		`CHK(r, est)
		rdr(CMD_CONFIG_READ, r);
		`CHK(r, ecf)
	endtask
	function automatic logic [23:0] ebase(input logic [7:0] c, input logic [23:0] a);
		ebase = (c == ERASE_64K) ? {a[23:16], 16'h0000} :
			(c == ERASE_32K) ? {a[23:15], 15'h0000} : {a[23:12], 12'h000};
	endfunction
	task automatic ers(input logic [7:0] c, input logic [23:0] a, input logic we);
		int n0;
		n0 = dev.erase_count;
		if (we) cmdn(CMD_WRITE_ENABLE);
		md = 1'($random(seed));
		xf(c, 1'h1, 1'h0, r);
		xf(a[23:16], 1'h1, 1'h0, r);
		xf(a[15:8], 1'h1, 1'h0, r);
		xf(a[7:0], 1'h0, 1'h0, r);
		`CHK(dev.erase_count, n0 + int'(we && est[3:2] == 2'h0))
		if (we && est[3:2] == 2'h0) `CHK(dev.erase_base, ebase(c, a))
		rdr(CMD_STATUS_READ, r);
		`CHK(r, est)
	endtask
	task automatic pins(input logic p);
		pn = p;
		wreg(REG_PINS, {7'h00, p});
		rreg(4'hF, r);
		`CHK(r, 8'h00)
		`CHK(protect_n, p)
	endtask
	initial begin
		repeat (20) @(posedge clk);
		rst <= 1'h0;
		`CHK(pause_n, 1'h1)
		rdr(CMD_STATUS_READ, r);
		`CHK(r, 8'h0C)
		status_write_cmd(8'h00, 8'h00, 1'h0);
		cmdn(CMD_WRITE_ENABLE);
		rdr(CMD_STATUS_READ, r);
		`CHK(r, est | 8'h02)
		repeat (4) status_write_cmd(8'($random(seed)) & 8'h0C, 8'h00, 1'h1);
		status_write_cmd(8'h8C, 8'h80, 1'h1);
		pins(1'h0);
		status_write_cmd(8'h00, 8'h00, 1'h1);
		pins(1'h1);
		status_write_cmd(8'h8C, 8'h82, 1'h1);
		pins(1'h0);
		status_write_cmd(8'h00, 8'h82, 1'h1);
		ers(ERASE_4K, 24'($random(seed)), 1'h0);
		ers(ERASE_32K, 24'($random(seed)), 1'h1);
		ers(ERASE_64K, 24'($random(seed)), 1'h1);
		ers(ERASE_4K, 24'($random(seed)), 1'h1);
		status_write_cmd(8'h88, 8'h00, 1'h1);
		status_write_cmd(8'h04, 8'h00, 1'h1);
		ers(ERASE_4K, 24'($random(seed)), 1'h1);
		cmdn(CMD_VOLATILE_LOCK);
		rdr(CMD_CONFIG_READ, r);
		`CHK(r, ecf)
		cmdn(CMD_WRITE_ENABLE);
		cmdn(CMD_VOLATILE_LOCK);
		ecf[CF_VOLATILE_LOCK] = 1'h1;
		status_write_cmd(8'h08, 8'h00, 1'h1);
		cmdn(CMD_QUAD_ENABLE);
		qm = 1'h1;
		status_write_cmd(8'h00, 8'h00, 1'h1);
		results();
	end
endmodule
